// File: rtl/nfs_pkg.sv
// Shared constants and types for the node frame sync port.
// Assumes a single 200 MHz clock domain.
package nfs_pkg;
    // Clock rate
    localparam int CLK_MHZ = 200;
    // Times as printed
    localparam int FRAME_MS = 10;
    localparam int PULSE_MIN_US = 5;
    localparam int PULSE_MAX_US = 1000;
    localparam int REGEN_MAX_NS = 500;
    // Cycle counts derived from the clock rate
    localparam int FRAME_CYC = FRAME_MS * 1000 * CLK_MHZ;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_US * CLK_MHZ + 0) / 1;
    localparam int PULSE_MAX_CYC = (PULSE_MAX_US * CLK_MHZ) / 1;
    localparam int REGEN_MAX_CYC = (REGEN_MAX_NS * CLK_MHZ) / 1000;
    // Period tolerance for a valid reference pulse train
    localparam int PERIOD_TOL_CYC = FRAME_CYC / 100;
    // Pin-to-alignment pipeline latency, preloaded into the tick counter
    localparam int PORT_LAT_CYC = 6;
    // Widths
    localparam int TICK_W = 21;
    localparam int WID_W = 18;
    localparam int STAMP_W = 12;
    // Reset values
    localparam logic [STAMP_W-1:0] FRAME_RST = 12'h000;
    localparam logic [TICK_W-1:0] TICK_RST = 21'h00_0000;

    typedef enum logic [1:0] {
        SRC_FREE = 2'b00,
        SRC_PORT = 2'b01,
        SRC_AIR = 2'b10
    } nfs_src_t;

    typedef struct packed {
        logic valid;
        logic [STAMP_W-1:0] probe_send_stamp;
    } nfs_probe_t;

    typedef struct packed {
        logic valid;
        logic [STAMP_W-1:0] probe_send_stamp;
        logic [STAMP_W-1:0] probe_receive_stamp;
        logic [STAMP_W-1:0] reply_send_stamp;
    } nfs_reply_t;
endpackage : nfs_pkg

// File: rtl/nfs_pulse_check.sv
// Reference pulse qualifier: checks high width and fall-to-fall period.
// Assumes level and edge inputs already synchronised to clk_i.
`timescale 1ns/1ps
module nfs_pulse_check
    import nfs_pkg::*;
#(
    parameter int FRAME_CYC_P = FRAME_CYC,
    parameter int PULSE_MAX_P = PULSE_MAX_CYC,
    parameter int TOL_P = PERIOD_TOL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic level_i,
    input wire logic rise_i,
    input wire logic fall_i,
    output logic valid_o,
    output logic mark_o
);
    logic [WID_W-1:0] high_reg;
    logic [TICK_W-1:0] per_reg;
    logic seen_reg;
    logic width_ok;
    logic per_ok;
    logic too_long;

    assign width_ok = (32'(high_reg) + 1 >= PULSE_MIN_CYC) &&
                      (32'(high_reg) + 1 <= PULSE_MAX_P);
    assign per_ok = (32'(per_reg) + 1 >= FRAME_CYC_P - TOL_P) &&
                    (32'(per_reg) + 1 <= FRAME_CYC_P + TOL_P);
    assign too_long = (32'(per_reg) > FRAME_CYC_P + TOL_P) ||
                      (level_i && 32'(high_reg) > PULSE_MAX_P);

    // High width counter, saturating
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            high_reg <= '0;
        end else if (rise_i) begin
            high_reg <= '0;
        end else if (level_i && high_reg != '1) begin
            high_reg <= high_reg + 1'b1;
        end
    end

    // Fall-to-fall period counter, saturating
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            per_reg <= TICK_RST;
            seen_reg <= 1'b0;
        end else if (fall_i) begin
            per_reg <= TICK_RST;
            seen_reg <= width_ok;
        end else if (per_reg != '1) begin
            per_reg <= per_reg + 1'b1;
        end
    end

    // [R21] Out-of-range pulses invalidate
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_o <= 1'b0;
            mark_o <= 1'b0;
        end else begin
            mark_o <= 1'b0;
            if (fall_i) begin
                valid_o <= seen_reg && width_ok && per_ok;
                mark_o <= seen_reg && width_ok && per_ok;
            end else if (too_long) begin
                valid_o <= 1'b0;
            end
        end
    end
endmodule : nfs_pulse_check

// File: rtl/nfs_frame_sync.sv
// Node frame sync top: reference port, frame counter, timing probe reply.
// Assumes one 200 MHz clock; probe and air-measurement inputs are
// synchronous, the reference pin is asynchronous.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Each received timing probe is answered with one timing reply frame.
// [R2] The reply returns the probe's controller send stamp unchanged.
// [R3] Controller stamps its probe at hand-off to transport.
// [R4] Receive stamp is station frame count when the probe arrives.
// [R5] Send stamp is station frame count when the reply is accepted.
// [R6] Input and output ports can each be disabled.
// [R7] Align to the port only while a valid pulse train is present.
// [R8] Regenerate the valid input pulse on the output port.
// [R9] Input-to-output regeneration delay stays within 500 ns.
// [R10] Source drives 100 Hz pulses, 5 us to 1 ms high.
// [R11] Successive reference pulses define a 10 ms frame period.
// [R12] Frame boundary taken from the falling edge.
// [R13] Satellite source aligns one frame in 100 to a whole second.
// [R14] Reference is more accurate than the local oscillator.
// [R15] Neighbouring inputs differ by at most 5 us.
// [R16] All cells share the one station frame timing.
// [R17] Without port reference, follow an active cell of a master.
// [R18] With no audible cell, use the port and act as reference.
// [R19] Over-air following corrects by measured propagation delay.
// [R20] With no reference at all, run free on the local clock.
// [R21] Pulses with bad width or period are invalid.
module nfs_frame_sync
    import nfs_pkg::*;
#(
    parameter int FRAME_CYC_P = FRAME_CYC,
    parameter int PULSE_MAX_P = PULSE_MAX_CYC,
    parameter int TOL_P = PERIOD_TOL_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic sync_in_i,
    input wire logic sync_in_en_i,
    input wire logic sync_out_en_i,
    input wire logic air_lock_i,
    input wire logic air_frame_i,
    input wire logic [TICK_W-1:0] air_delay_i,
    input wire nfs_probe_t probe_i,
    input wire logic reply_ready_i,
    output logic probe_ready_o,
    output nfs_reply_t reply_o,
    output logic sync_out_o,
    output logic port_valid_o,
    output nfs_src_t timing_src_o,
    output logic frame_start_o,
    output logic [STAMP_W-1:0] station_frame_counter_o
);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(FRAME_CYC_P - 1);
    localparam logic [TICK_W-1:0] TICK_HALF = TICK_W'(FRAME_CYC_P / 2);
    localparam logic [TICK_W-1:0] TICK_PORT = TICK_W'(PORT_LAT_CYC);

    logic rst_s1_reg;
    logic rst_b;
    logic [2:0] pin_reg;
    logic lvl_reg;
    logic rise_reg;
    logic fall_reg;
    logic chk_valid;
    logic chk_mark;
    logic [TICK_W-1:0] tick_reg;
    logic [TICK_W-1:0] tick_next;
    logic [STAMP_W-1:0] frame_next;
    logic start_next;
    logic align;
    logic [TICK_W-1:0] align_tick;
    nfs_src_t src_next;
    logic pending_reg;

    // Reset release through two flops
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_reg <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b <= rst_s1_reg;
        end
    end

    // Pin synchroniser; level changes when stages two and three agree
    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            pin_reg <= 3'b000;
            lvl_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            pin_reg <= {pin_reg[1:0], sync_in_i};
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            // [R6] Disabled input reads as idle
            if (!sync_in_en_i) begin
                lvl_reg <= 1'b0;
                fall_reg <= lvl_reg;
            end else if (pin_reg[1] == pin_reg[2] && pin_reg[2] != lvl_reg) begin
                lvl_reg <= pin_reg[2];
                rise_reg <= pin_reg[2];
                // [R12] Falling edge marks the frame
                fall_reg <= !pin_reg[2];
            end
        end
    end

    nfs_pulse_check #(
        .FRAME_CYC_P(FRAME_CYC_P),
        .PULSE_MAX_P(PULSE_MAX_P),
        .TOL_P(TOL_P)
    ) u_check (
        .clk_i(mclk_i),
        .rst_b_i(rst_b),
        .level_i(lvl_reg),
        .rise_i(rise_reg),
        .fall_i(fall_reg),
        .valid_o(chk_valid),
        .mark_o(chk_mark)
    );

    // [R8] Regenerate the qualified pulse; [R9] few cycles of delay
    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            sync_out_o <= 1'b0;
            port_valid_o <= 1'b0;
        end else begin
            sync_out_o <= sync_out_en_i && chk_valid && lvl_reg;
            port_valid_o <= chk_valid;
        end
    end

    // Source choice: port, then air master, then free running
    always_comb begin
        src_next = SRC_FREE;
        align = 1'b0;
        align_tick = TICK_PORT;
        if (chk_valid) begin
            // [R7] [R18] Valid port pulse makes this a reference
            src_next = SRC_PORT;
            align = chk_mark;
        end else if (air_lock_i) begin
            // [R17] Follow the master cell over the air
            src_next = SRC_AIR;
            align = air_frame_i;
            // [R19] Preload by propagation delay
            align_tick = air_delay_i;
        end
        // [R20] Otherwise no alignment: free running
    end

    // [R11] Frame tick and counter
    always_comb begin
        tick_next = tick_reg + 1'b1;
        frame_next = station_frame_counter_o;
        start_next = 1'b0;
        if (align) begin
            tick_next = align_tick;
            if (tick_reg >= TICK_HALF) begin
                frame_next = station_frame_counter_o + 1'b1;
                start_next = 1'b1;
            end
        end else if (tick_reg >= TICK_LAST) begin
            tick_next = TICK_RST;
            frame_next = station_frame_counter_o + 1'b1;
            start_next = 1'b1;
        end
    end

    // [R16] One frame timing for every cell
    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            tick_reg <= TICK_RST;
            station_frame_counter_o <= FRAME_RST;
            frame_start_o <= 1'b0;
            timing_src_o <= SRC_FREE;
        end else begin
            tick_reg <= tick_next;
            station_frame_counter_o <= frame_next;
            frame_start_o <= start_next;
            timing_src_o <= src_next;
        end
    end

    // Timing probe reply, one outstanding
    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            pending_reg <= 1'b0;
            probe_ready_o <= 1'b0;
            reply_o <= '0;
        end else begin
            // Ready only when nothing will be pending after this edge
            probe_ready_o <= !((probe_i.valid && probe_ready_o) ||
                               (pending_reg && !reply_ready_i));
            if (pending_reg && reply_ready_i) begin
                pending_reg <= 1'b0;
                reply_o.valid <= 1'b0;
            end
            if (probe_i.valid && probe_ready_o) begin
                // [R1] Answer every accepted probe
                pending_reg <= 1'b1;
                reply_o.valid <= 1'b1;
                // [R2] Controller stamp echoed
                reply_o.probe_send_stamp <= probe_i.probe_send_stamp;
                // [R4] Stamp on arrival
                reply_o.probe_receive_stamp <= station_frame_counter_o;
            end
            // [R5] Send stamp tracks the counter until accepted
            if (!(pending_reg && reply_ready_i)) begin
                reply_o.reply_send_stamp <= frame_next;
            end
        end
    end
endmodule : nfs_frame_sync

// File: tb/nfs_frame_sync_monitor.sv
// Checker for the frame sync top, watching its ports only.
// Bound into the design from the bench; one clock domain.
`timescale 1ns/1ps
module nfs_frame_sync_chk
    import nfs_pkg::*;
#(
    parameter int FRAME_CYC_P = FRAME_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic sync_in_i,
    input wire logic sync_out_en_i,
    input wire nfs_probe_t probe_i,
    input wire logic reply_ready_i,
    input wire logic probe_ready_o,
    input wire nfs_reply_t reply_o,
    input wire logic sync_out_o,
    input wire logic port_valid_o,
    input wire nfs_src_t timing_src_o,
    input wire logic frame_start_o,
    input wire logic [STAMP_W-1:0] station_frame_counter_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic take;
    int gap;
    logic [3:0] since;
    assign take = probe_i.valid && probe_ready_o;
    // Cycles since last frame start while running free
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) gap <= 0;
        else if (timing_src_o != SRC_FREE || port_valid_o) gap <= 0;
        else if (frame_start_o) gap <= 1;
        else if (gap != 0) gap <= gap + 1;
    end
    // Cycles since any frame start, saturating
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) since <= '1;
        else if (frame_start_o) since <= '0;
        else if (since != '1) since <= since + 1'b1;
    end
    a_reply_follows: assert property (take |=> reply_o.valid)
        else $error("no reply after probe");
    a_stamp_echo: assert property (take |=>
        reply_o.probe_send_stamp == $past(probe_i.probe_send_stamp))
        else $error("probe stamp not echoed");
    a_recv_stamp: assert property (take |=>
        reply_o.probe_receive_stamp == $past(station_frame_counter_o))
        else $error("receive stamp wrong");
    a_send_stamp: assert property (reply_o.valid && reply_ready_i |->
        reply_o.reply_send_stamp == station_frame_counter_o)
        else $error("send stamp wrong");
    a_regen_delay: assert property (port_valid_o && sync_out_en_i &&
        $rose(sync_in_i) |-> ##[1:99] sync_out_o)
        else $error("pulse not regenerated in time");
    a_frame_on_fall: assert property (timing_src_o == SRC_PORT &&
        $fell(sync_in_i) |-> frame_start_o || since < 4'h8 or
        ##[1:12] frame_start_o)
        else $error("no frame start after falling edge");
    a_free_period: assert property (frame_start_o && gap != 0 &&
        timing_src_o == SRC_FREE && !port_valid_o |-> gap == FRAME_CYC_P)
        else $error("free running frame period wrong");
    a_out_disabled: assert property (!sync_out_en_i &&
        !$past(sync_out_en_i, 2) |-> !sync_out_o)
        else $error("output port driven while disabled");
    c_probe: cover property (take);
    c_regen: cover property ($rose(sync_out_o));
    c_air: cover property (timing_src_o == SRC_AIR);
endmodule : nfs_frame_sync_chk

// File: tb/nfs_ref_src.sv
// Reference pulse source standing at the sync input pin.
// Runs off the bench clock with a small skew.
`timescale 1ns/1ps
module nfs_ref_src (
    input wire logic clk_i,
    input wire logic on_i,
    input wire logic [20:0] width_i,
    input wire logic [20:0] period_i,
    output logic pulse_o
);
    int cnt = 0;
    initial pulse_o = 1'b0;
    always @(posedge clk_i) begin
        cnt = (on_i && cnt < period_i - 1) ? cnt + 1 : 0;
        pulse_o <= #1.3 on_i && cnt < width_i;
    end
endmodule : nfs_ref_src

// File: tb/tb.sv
// Bench for the frame sync top: probes, reference port, air follow.
// Small frame parameters keep the run short.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import nfs_pkg::*;
    localparam int FC = 2000;
    logic mclk_i = 0, rst_b_i = 0, sync_in_i, sync_in_en_i = 1;
    logic sync_out_en_i = 0, air_lock_i = 0, air_frame_i = 0, ref_on = 0;
    logic reply_ready_i = 0, probe_ready_o, sync_out_o, port_valid_o;
    logic frame_start_o;
    logic [TICK_W-1:0] air_delay_i = 21'd100;
    logic [20:0] ref_w = 21'd1100;
    logic [STAMP_W-1:0] station_frame_counter_o;
    nfs_probe_t probe_i = '0;
    nfs_reply_t reply_o;
    nfs_src_t timing_src_o;
    logic [2*STAMP_W-1:0] exp_q[$];
    int fail_count = 0, num_checks = 0, seed = 34005, hits = 0, k, w;
    logic rdy;
    always #2.5 mclk_i = ~mclk_i;
    nfs_ref_src ref_src (.clk_i(mclk_i), .on_i(ref_on), .width_i(ref_w),
        .period_i(21'd2000), .pulse_o(sync_in_i));
    nfs_frame_sync #(.FRAME_CYC_P(FC), .PULSE_MAX_P(1200), .TOL_P(40)) uut (.*);
    task automatic summarize;
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic send_probe(input logic [STAMP_W-1:0] s);
        int n;
        for (n = 0; n < 100 && probe_ready_o !== 1'b1; n++) @(negedge mclk_i);
        if (probe_ready_o !== 1'b1) fail_count++;
        if (probe_ready_o !== 1'b1) summarize();
        exp_q.push_back({s, station_frame_counter_o});
        probe_i = '{1'b1, s};
        @(negedge mclk_i);
        probe_i = '0;
    endtask : send_probe
    // Reply scoreboard and random transport stalls
    always @(negedge mclk_i) begin
        if (sync_out_o === 1'b1) hits++;
        rdy = 1'($random(seed));
        if (rst_b_i && reply_o.valid === 1'b1 && rdy) begin
            `CHK({reply_o.probe_send_stamp, reply_o.probe_receive_stamp}, exp_q.pop_front())
            `CHK(reply_o.reply_send_stamp, station_frame_counter_o)
        end
        reply_ready_i <= rdy;
    end
    initial begin
        repeat (90000) @(posedge mclk_i);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (2) @(negedge mclk_i);
        rst_b_i = 1;
        repeat (4) @(negedge mclk_i);
        `CHK(timing_src_o, SRC_FREE)
        fork
            repeat (12) send_probe(12'($random(seed)));
        join_none
        sync_out_en_i = 1;
        ref_on = 1;
        repeat (5 * FC) @(negedge mclk_i);
        `CHK(port_valid_o, 1'b1)
        `CHK(timing_src_o, SRC_PORT)
        `CHK(hits > 0, 1'b1)
        sync_out_en_i = 0;
        @(negedge mclk_i);
        hits = 0;
        repeat (2 * FC) @(negedge mclk_i);
        `CHK(hits, 0)
        `CHK(port_valid_o, 1'b1)
        sync_out_en_i = 1;
        for (w = 0; w < 2; w++) begin
            ref_on = 0;
            repeat (3 * FC) @(negedge mclk_i);
            ref_w = w ? 21'd1300 : 21'd500;
            ref_on = 1;
            hits = 0;
            repeat (5 * FC) @(negedge mclk_i);
            `CHK(port_valid_o, 1'b0)
            `CHK(hits, 0)
        end
        ref_on = 0;
        sync_in_en_i = 0;
        air_lock_i = 1;
        repeat (4) begin
            air_frame_i = 1;
            @(negedge mclk_i);
            air_frame_i = 0;
            repeat (FC - 1) @(negedge mclk_i);
        end
        for (k = 0; k < FC && frame_start_o !== 1'b1; k++) @(negedge mclk_i);
        `CHK(k > FC - 110 && k < FC - 90, 1'b1)
        `CHK(timing_src_o, SRC_AIR)
        air_lock_i = 0;
        repeat (3 * FC) @(negedge mclk_i);
        `CHK(timing_src_o, SRC_FREE)
        `CHK(exp_q.size(), 0)
        summarize();
    end
endmodule : tb
bind nfs_frame_sync nfs_frame_sync_chk #(.FRAME_CYC_P(FRAME_CYC_P)) chk (.*);
